// >>> rtl/cmgc_map.svh
// cmgc_map.svh: register offsets, field positions, reset values, timing counts
// assumes: included by bare name from the clock mode and gain control files
`ifndef CMGC_MAP_SVH
`define CMGC_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CMGC_OFS_MODE 8'h00
`define CMGC_OFS_MOSC 8'h01
`define CMGC_OFS_PCLK 8'h02
`define CMGC_OFS_STAT 8'h03

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CMGC_MODE_MAIN_EXT 7
`define CMGC_MODE_MAIN_PIN 6
`define CMGC_MODE_SUB_EXT 5
`define CMGC_MODE_SUB_PIN 4
`define CMGC_MODE_GAIN 0
`define CMGC_MOSC_STOP 7
`define CMGC_PCLK_RSV_HI 7
`define CMGC_PCLK_SUB_STS 5
`define CMGC_PCLK_SUB_START 4
`define CMGC_PCLK_RSV_LO 3
`define CMGC_STAT_STALL 0
`define CMGC_STAT_LOCK 1
`define CMGC_STAT_STAB 2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CMGC_MODE_RST 8'h00
`define CMGC_MOSC_RST 8'h80
`define CMGC_PCLK_DIV_RST 3'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CMGC_CLK_PERIOD_NS 100
`define CMGC_STALL_MIN_NS 4060
`define CMGC_STALL_MAX_NS 16120
`define CMGC_STALL_MIN_CYC ((`CMGC_STALL_MIN_NS + `CMGC_CLK_PERIOD_NS - 1) / `CMGC_CLK_PERIOD_NS)
`define CMGC_STALL_MAX_CYC (`CMGC_STALL_MAX_NS / `CMGC_CLK_PERIOD_NS)
`define CMGC_EXT_STALL_CLKS 160
`define CMGC_STAB_CYC_DEF 256

`endif

// >>> rtl/cmgc_pkg.sv
// cmgc_pkg.sv: types of the clock mode and gain control block
// assumes: compiled before every other file of the block
package cmgc_pkg;

   // ----------------------------------------------------------------
   // cpu clock source and stall kinds
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      CMGC_SRC_INT_HS,
      CMGC_SRC_MAIN_XTAL,
      CMGC_SRC_MAIN_EXT,
      CMGC_SRC_SUB
   } cmgc_src_type;

   typedef enum logic [1:0] {
      CMGC_ST_RUN,
      CMGC_ST_TIME,
      CMGC_ST_EXT,
      CMGC_ST_STAB
   } cmgc_stall_type;

   // ----------------------------------------------------------------
   // register bus request and mode outputs
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } cmgc_bus_req_type;

   typedef struct packed {
      logic main_ext_clock_input_select;
      logic main_osc_pin_mode_select;
      logic main_osc_stop;
      logic sub_osc_start_select;
      logic sub_ext_clock_input_select;
      logic sub_osc_pin_mode_select;
      logic high_freq_osc_gain_select;
   } cmgc_mode_type;

endpackage : cmgc_pkg

// >>> rtl/cmgc_stall_timer.sv
// cmgc_stall_timer.sv: down counter that holds busy for a loaded number of steps
// assumes: start is a one-cycle pulse; tick is a one-cycle pulse synchronous to sys_clk
module cmgc_stall_timer #(
   parameter int W = 9
) (
   input wire logic sys_clk, // system clock
   input wire logic rst, // synchronous reset, active high
   input wire logic start, // load the count
   input wire logic [W-1:0] load_val, // steps to wait
   input wire logic use_tick, // step on tick instead of every cycle
   input wire logic tick, // external step pulse
   output logic busy, // count not yet exhausted
   output logic last // final step taken this cycle
);

   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic use_tick_q;
   logic use_tick_d;
   logic step;

   // step source and end of count
   assign step = use_tick_q ? tick : 1'b1;
   assign busy = (cnt_q != '0);
   assign last = busy && step && (cnt_q == W'(1));

   // next count
   always_comb begin
      cnt_d = cnt_q;
      use_tick_d = use_tick_q;
      if (start) begin
         cnt_d = load_val;
         use_tick_d = use_tick;
      end else if (busy && step) begin
         cnt_d = cnt_q - W'(1);
      end
   end

   // count registers
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cnt_q <= '0;
         use_tick_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         use_tick_q <= use_tick_d;
      end
   end

endmodule : cmgc_stall_timer

// >>> rtl/cmgc_top.sv
// cmgc_top.sv: clock mode registers, write-once gain bit and cpu clock stall control
// assumes: register strobes one cycle long, never together; ext_clk_tick marks one
// external main clock period; stop_mode is high while the cpu sits in stop mode
//
// Overview of operation
// - The gain bit can change its value only once between two resets.
// - Setting the gain bit while the crystal clocks the cpu stops the cpu clock 4.06 to 16.12 us.
// - Setting the gain bit while the external main clock drives the cpu stops it for 160 clocks.
// - With gain set, stop release stalls 4.06-16.12 us on internal clock or 160 ext clocks.
// - With the crystal clocking the cpu, stop release waits the oscillation settling count.
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`include "cmgc_map.svh"

module cmgc_top #(
   parameter int STAB_CYCLES = `CMGC_STAB_CYC_DEF, // crystal settling count
   parameter int TW = 9 // stall counter width
) (
   input wire logic sys_clk, // system clock, 10 MHz
   input wire logic rst, // synchronous reset, active high
   input wire cmgc_pkg::cmgc_bus_req_type bus_req, // register bus request
   output logic [7:0] rdata, // read data, cycle after read strobe
   input wire cmgc_pkg::cmgc_src_type cpu_clk_src, // clock now feeding the cpu
   input wire logic ext_clk_tick, // one pulse per external main clock
   input wire logic stop_mode, // cpu in stop mode
   output logic cpu_clk_enable, // cpu clock supplied
   output cmgc_pkg::cmgc_mode_type mode // pin mode and gain settings
);

   localparam int TIME_CYC = `CMGC_STALL_MIN_CYC;
   localparam int EXT_CLKS = `CMGC_EXT_STALL_CLKS;
   localparam int TIME_MAX_CYC = `CMGC_STALL_MAX_CYC;
   localparam logic [7:0] MOSC_RST = `CMGC_MOSC_RST;

   cmgc_pkg::cmgc_mode_type mode_q;
   cmgc_pkg::cmgc_mode_type mode_d;
   logic gain_lock_q;
   logic gain_lock_d;
   logic [2:0] clk_div_q;
   logic [2:0] clk_div_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   cmgc_pkg::cmgc_stall_type st_q;
   cmgc_pkg::cmgc_stall_type st_d;
   logic stop_q;
   logic on_sub;
   logic wr_mode;
   logic wr_mosc;
   logic wr_pclk;
   logic gain_rise;
   logic stop_release;
   logic t_start;
   logic [TW-1:0] t_load;
   logic t_use_tick;
   logic t_busy;
   logic t_last;

   assign on_sub = (cpu_clk_src == cmgc_pkg::CMGC_SRC_SUB);
   assign wr_mode = bus_req.wr && (bus_req.addr == `CMGC_OFS_MODE);
   assign wr_mosc = bus_req.wr && (bus_req.addr == `CMGC_OFS_MOSC);
   assign wr_pclk = bus_req.wr && (bus_req.addr == `CMGC_OFS_PCLK);
   assign stop_release = stop_q && !stop_mode;

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------

   // mode registers with their write interlocks
   always_comb begin
      mode_d = mode_q;
      gain_lock_d = gain_lock_q;
      clk_div_d = clk_div_q;
      gain_rise = 1'b0;
      if (wr_mode) begin
         // main pin mode only while the main oscillator is stopped
         if (mode_q.main_osc_stop) begin
            mode_d.main_ext_clock_input_select = bus_req.wdata[`CMGC_MODE_MAIN_EXT];
            mode_d.main_osc_pin_mode_select = bus_req.wdata[`CMGC_MODE_MAIN_PIN];
         end
         // sub pin mode only while the cpu does not run on the sub clock
         if (!on_sub) begin
            mode_d.sub_ext_clock_input_select = bus_req.wdata[`CMGC_MODE_SUB_EXT];
            mode_d.sub_osc_pin_mode_select = bus_req.wdata[`CMGC_MODE_SUB_PIN];
         end
         // first real change of the gain bit locks it until reset
         if (!gain_lock_q &&
             (bus_req.wdata[`CMGC_MODE_GAIN] != mode_q.high_freq_osc_gain_select)) begin
            mode_d.high_freq_osc_gain_select = bus_req.wdata[`CMGC_MODE_GAIN];
            gain_lock_d = 1'b1;
            gain_rise = bus_req.wdata[`CMGC_MODE_GAIN];
         end
      end
      if (wr_mosc) begin
         mode_d.main_osc_stop = bus_req.wdata[`CMGC_MOSC_STOP];
      end
      if (wr_pclk) begin
         if (!on_sub) begin
            mode_d.sub_osc_start_select = bus_req.wdata[`CMGC_PCLK_SUB_START];
         end
         clk_div_d = bus_req.wdata[2:0];
      end
   end

   // register read mux, data valid one cycle after the strobe
   always_comb begin
      rdata_d = 8'h00;
      if (bus_req.rd) begin
         unique case (bus_req.addr)
            `CMGC_OFS_MODE: begin
               rdata_d[`CMGC_MODE_MAIN_EXT] = mode_q.main_ext_clock_input_select;
               rdata_d[`CMGC_MODE_MAIN_PIN] = mode_q.main_osc_pin_mode_select;
               rdata_d[`CMGC_MODE_SUB_EXT] = mode_q.sub_ext_clock_input_select;
               rdata_d[`CMGC_MODE_SUB_PIN] = mode_q.sub_osc_pin_mode_select;
               rdata_d[`CMGC_MODE_GAIN] = mode_q.high_freq_osc_gain_select;
            end
            `CMGC_OFS_MOSC: begin
               rdata_d[`CMGC_MOSC_STOP] = mode_q.main_osc_stop;
            end
            `CMGC_OFS_PCLK: begin
               // reserved bits 3 and 7 always read zero
               rdata_d[`CMGC_PCLK_SUB_STS] = on_sub;
               rdata_d[`CMGC_PCLK_SUB_START] = mode_q.sub_osc_start_select;
               rdata_d[2:0] = clk_div_q;
            end
            `CMGC_OFS_STAT: begin
               rdata_d[`CMGC_STAT_STALL] = t_busy;
               rdata_d[`CMGC_STAT_LOCK] = gain_lock_q;
               rdata_d[`CMGC_STAT_STAB] = (st_q == cmgc_pkg::CMGC_ST_STAB);
            end
            default: rdata_d = 8'h00; // unmapped reads as zero
         endcase
      end
   end

   // register state
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mode_q <= '0;
         mode_q.main_osc_stop <= MOSC_RST[`CMGC_MOSC_STOP];
         gain_lock_q <= 1'b0;
         clk_div_q <= `CMGC_PCLK_DIV_RST;
         rdata_q <= 8'h00;
      end else begin
         mode_q <= mode_d;
         gain_lock_q <= gain_lock_d;
         clk_div_q <= clk_div_d;
         rdata_q <= rdata_d;
      end
   end

   assign rdata = rdata_q;
   assign mode = mode_q;

   // ----------------------------------------------------------------
   // cpu clock stall control
   // ----------------------------------------------------------------

   // choose which stall, if any, to start
   always_comb begin
      t_start = 1'b0;
      t_load = '0;
      t_use_tick = 1'b0;
      st_d = st_q;
      if (st_q != cmgc_pkg::CMGC_ST_RUN && !t_busy) begin
         st_d = cmgc_pkg::CMGC_ST_RUN;
      end
      if (gain_rise && cpu_clk_src == cmgc_pkg::CMGC_SRC_MAIN_XTAL) begin
         t_start = 1'b1;
         t_load = TW'(TIME_CYC);
         st_d = cmgc_pkg::CMGC_ST_TIME;
      end else if (gain_rise && cpu_clk_src == cmgc_pkg::CMGC_SRC_MAIN_EXT) begin
         t_start = 1'b1;
         t_load = TW'(EXT_CLKS);
         t_use_tick = 1'b1;
         st_d = cmgc_pkg::CMGC_ST_EXT;
      end else if (stop_release) begin
         if (cpu_clk_src == cmgc_pkg::CMGC_SRC_MAIN_XTAL) begin
            t_start = 1'b1;
            t_load = TW'(STAB_CYCLES);
            st_d = cmgc_pkg::CMGC_ST_STAB;
         end else if (mode_q.high_freq_osc_gain_select &&
                      cpu_clk_src == cmgc_pkg::CMGC_SRC_INT_HS) begin
            t_start = 1'b1;
            t_load = TW'(TIME_CYC);
            st_d = cmgc_pkg::CMGC_ST_TIME;
         end else if (mode_q.high_freq_osc_gain_select &&
                      cpu_clk_src == cmgc_pkg::CMGC_SRC_MAIN_EXT) begin
            t_start = 1'b1;
            t_load = TW'(EXT_CLKS);
            t_use_tick = 1'b1;
            st_d = cmgc_pkg::CMGC_ST_EXT;
         end
      end
   end

   // stall kind and stop edge registers
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_q <= cmgc_pkg::CMGC_ST_RUN;
         stop_q <= 1'b0;
      end else begin
         st_q <= st_d;
         stop_q <= stop_mode;
      end
   end

   // stall length counter
   cmgc_stall_timer #(
      .W(TW)
   ) u_timer (
      .sys_clk(sys_clk),
      .rst(rst),
      .start(t_start),
      .load_val(t_load),
      .use_tick(t_use_tick),
      .tick(ext_clk_tick),
      .busy(t_busy),
      .last(t_last)
   );

   // cpu clock gated during stop mode and any stall
   assign cpu_clk_enable = !stop_mode && !t_busy;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------

   // helper: length of the current stall in cycles and in external ticks
   logic [TW-1:0] hlp_cyc_q;
   logic [TW-1:0] hlp_tick_q;
   always_ff @(posedge sys_clk) begin
      if (rst || !t_busy || t_start) begin
         hlp_cyc_q <= '0;
         hlp_tick_q <= '0;
      end else begin
         hlp_cyc_q <= hlp_cyc_q + TW'(1);
         hlp_tick_q <= hlp_tick_q + TW'(ext_clk_tick);
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   // write-once gain bit
   AST_GAIN_ONCE: assert property (
      gain_lock_q |=> $stable(mode_q.high_freq_osc_gain_select))
      else $error("gain bit changed after lock");

   // stalls started by setting the gain bit
   AST_XTAL_STALL: assert property (
      (gain_rise && cpu_clk_src == cmgc_pkg::CMGC_SRC_MAIN_XTAL) |=> !cpu_clk_enable [*8])
      else $error("cpu clock not stopped after gain set on crystal");
   AST_EXT_STALL: assert property (
      (gain_rise && cpu_clk_src == cmgc_pkg::CMGC_SRC_MAIN_EXT)
      |=> (st_q == cmgc_pkg::CMGC_ST_EXT && !cpu_clk_enable))
      else $error("cpu clock not stopped after gain set on external clock");

   // stall lengths: timed stall inside its window, counted stall exact in ticks
   AST_TIME_LEN: assert property (
      (t_last && st_q == cmgc_pkg::CMGC_ST_TIME) |-> (int'(hlp_cyc_q) + 1 == TIME_CYC))
      else $error("timed stall length wrong");
   AST_TIME_MAX: assert property (
      (t_busy && st_q == cmgc_pkg::CMGC_ST_TIME) |-> (int'(hlp_cyc_q) < TIME_MAX_CYC))
      else $error("timed stall longer than allowed");
   AST_EXT_LEN: assert property (
      (t_last && st_q == cmgc_pkg::CMGC_ST_EXT) |-> (int'(hlp_tick_q) + 1 == EXT_CLKS))
      else $error("external clock stall length wrong");

   // stop release: stall with gain set, settling wait on the crystal
   AST_STOP_INT: assert property (
      (stop_release && !gain_rise && mode_q.high_freq_osc_gain_select
      && cpu_clk_src == cmgc_pkg::CMGC_SRC_INT_HS)
      |=> (st_q == cmgc_pkg::CMGC_ST_TIME && !cpu_clk_enable))
      else $error("no stall after stop release on internal clock");
   AST_STOP_EXT: assert property (
      (stop_release && !gain_rise && mode_q.high_freq_osc_gain_select
      && cpu_clk_src == cmgc_pkg::CMGC_SRC_MAIN_EXT)
      |=> (st_q == cmgc_pkg::CMGC_ST_EXT && !cpu_clk_enable))
      else $error("no stall after stop release on external clock");
   AST_STOP_XTAL: assert property (
      (stop_release && !gain_rise && cpu_clk_src == cmgc_pkg::CMGC_SRC_MAIN_XTAL)
      |=> (st_q == cmgc_pkg::CMGC_ST_STAB && t_busy))
      else $error("no settling wait after stop release on crystal");

   // automatic resume, and no stall from a gain write after lock
   AST_RESUME: assert property (
      (t_last && !t_start) ##1 !stop_mode |-> cpu_clk_enable)
      else $error("cpu clock not resumed after stall");
   AST_LOCK_QUIET: assert property (
      (wr_mode && gain_lock_q && !stop_release) |-> !t_start)
      else $error("gain write after lock started a stall");

   // main scenarios
   COV_GAIN_XTAL: cover property (gain_rise && cpu_clk_src == cmgc_pkg::CMGC_SRC_MAIN_XTAL);
   COV_EXT_DONE: cover property (t_last && st_q == cmgc_pkg::CMGC_ST_EXT);
   COV_STAB_DONE: cover property (t_last && st_q == cmgc_pkg::CMGC_ST_STAB);
   COV_TIME_DONE: cover property (t_last && st_q == cmgc_pkg::CMGC_ST_TIME);

endmodule : cmgc_top

// >>> tb/cmgc_ext_clk_model.sv
// cmgc_ext_clk_model.sv: external main clock source, one tick per modelled clock period
// assumes: the bench sets period to 2 or more; ticks are synchronous to sys_clk
module cmgc_ext_clk_model (
   input wire logic sys_clk, // system clock
   input wire logic run, // source active
   input wire logic [3:0] period, // system cycles per external clock
   output logic tick // one pulse per external clock
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt_q;

   // ----------------------------------------------------------------
   // divider; a slow period makes the stall stretch over many cycles
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!run) begin
         cnt_q <= 4'h0;
         tick <= 1'b0;
      end else begin
         cnt_q <= (cnt_q + 4'h1 >= period) ? 4'h0 : cnt_q + 4'h1;
         tick <= (cnt_q == 4'h0);
      end
   end
endmodule : cmgc_ext_clk_model

// >>> tb/testbench.sv
// testbench.sv: self-checking bench for the clock mode and gain control block
// assumes: cmgc_pkg compiled first; small settling count to keep the run short
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int STAB = 8;
   localparam int T_LO = (4060 + 99) / 100;
   localparam int T_HI = 16120 / 100;
   localparam logic [7:0] RA [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h5a};
   localparam logic [7:0] RE [5] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] MS [3] = '{8'h80, 8'h00, 8'h80};
   localparam logic [7:0] MW [3] = '{8'hc0, 8'h00, 8'h40};
   localparam logic [7:0] ME [3] = '{8'hc0, 8'hc0, 8'h40};
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   cmgc_pkg::cmgc_bus_req_type bus_req = '0;
   cmgc_pkg::cmgc_src_type cpu_clk_src = cmgc_pkg::CMGC_SRC_INT_HS;
   cmgc_pkg::cmgc_mode_type mode;
   logic [7:0] rdata;
   logic ext_clk_tick;
   logic stop_mode = 1'b0;
   logic cpu_clk_enable;
   logic [3:0] ext_period = 4'h3;
   logic [15:0] lfsr_q = 16'h5060;
   int err_count = 0;
   int checks_done = 0;

   // ----------------------------------------------------------------
   // design, far-side clock source and clock
   // ----------------------------------------------------------------
   cmgc_top #(.STAB_CYCLES(STAB), .TW(9)) dut (.sys_clk(sys_clk), .rst(rst),
      .bus_req(bus_req), .rdata(rdata), .cpu_clk_src(cpu_clk_src),
      .ext_clk_tick(ext_clk_tick), .stop_mode(stop_mode),
      .cpu_clk_enable(cpu_clk_enable), .mode(mode));
   cmgc_ext_clk_model src_model (.sys_clk(sys_clk), .run(!rst), .period(ext_period),
      .tick(ext_clk_tick));
   initial forever #50 sys_clk = ~sys_clk;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr_next

   // processor clock register as software should see it
   function automatic logic [7:0] exp_pclk(input logic [7:0] p, input logic [7:0] w,
                                           input logic sub);
      return {2'b00, sub, sub ? p[4] : w[4], 1'b0, w[2:0]};
   endfunction : exp_pclk

   task automatic final_report();
      if (err_count == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : final_report

   task automatic chk_val(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask : chk_val

   task automatic chk_rng(input int got, input int lo, input int hi, input string what);
      checks_done++;
      if (got < lo || got > hi) begin
         err_count++;
         $display("[FAIL] %0t %s: got %0d expected %0d..%0d", $time, what, got, lo, hi);
      end
   endtask : chk_rng

   task automatic reset_dut(input cmgc_pkg::cmgc_src_type s);
      @(posedge sys_clk);
      rst <= 1'b1;
      cpu_clk_src <= s;
      lfsr_q = lfsr_next(lfsr_q);
      ext_period <= 4'h2 + {1'b0, lfsr_q[2:0]};
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
   endtask : reset_dut

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      bus_req.wr <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      bus_req.rd <= 1'b0;
      @(negedge sys_clk);
      d = rdata;
   endtask : reg_rd

   // count cycles and ticks while the cpu clock is withheld
   task automatic measure(output int cyc, output int ticks);
      cyc = 0;
      ticks = 0;
      for (int i = 0; i < 3000; i++) begin
         @(negedge sys_clk);
         if (cpu_clk_enable === 1'b1) return;
         cyc++;
         if (ext_clk_tick === 1'b1) ticks++;
      end
      err_count++;
      $display("[FAIL] %0t cpu clock never resumed", $time);
      final_report();
   endtask : measure

   task automatic stop_release(output int cyc, output int ticks);
      @(posedge sys_clk);
      stop_mode <= 1'b1;
      repeat (3) @(posedge sys_clk);
      stop_mode <= 1'b0;
      @(posedge sys_clk);
      measure(cyc, ticks);
   endtask : stop_release

   // read status while a stop release stall runs, then let it finish
   task automatic stall_status(input logic [7:0] exp);
      int n;
      int t;
      logic [7:0] d;
      @(posedge sys_clk);
      stop_mode <= 1'b1;
      repeat (3) @(posedge sys_clk);
      stop_mode <= 1'b0;
      reg_rd(8'h03, d);
      chk_val(d, exp, "status during stall");
      measure(n, t);
   endtask : stall_status

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      int n;
      int t;
      logic [7:0] d;
      logic [7:0] w;
      logic [7:0] ep;
      logic [1:0] es;
      logic sub;
      reset_dut(cmgc_pkg::CMGC_SRC_INT_HS);
      for (int i = 0; i < 5; i++) begin
         reg_rd(RA[i], d);
         chk_val(d, RE[i], "reset value");
      end
      for (int i = 0; i < 3; i++) begin
         reg_wr(8'h01, MS[i]);
         reg_wr(8'h00, MW[i]);
         reg_rd(8'h00, d);
         chk_val(d, ME[i], "main pin mode bits");
      end
      chk_val({6'h00, mode.main_ext_clock_input_select, mode.main_osc_pin_mode_select},
              8'h01, "main mode output");
      ep = 8'h00;
      es = 2'b00;
      for (int i = 0; i < 12; i++) begin
         lfsr_q = lfsr_next(lfsr_q);
         sub = lfsr_q[8] | (i == 1);
         w = lfsr_q[7:0] & 8'h77;
         @(posedge sys_clk);
         cpu_clk_src <= sub ? cmgc_pkg::CMGC_SRC_SUB : cmgc_pkg::CMGC_SRC_INT_HS;
         reg_wr(8'h02, w);
         reg_wr(8'h00, {2'b01, w[5:4], 4'h0});
         ep = exp_pclk(ep, w, sub);
         es = sub ? es : w[5:4];
         reg_rd(8'h02, d);
         chk_val(d, ep, "processor clock register");
         reg_rd(8'h00, d);
         chk_val(d, {2'b01, es, 4'h0}, "sub mode bits");
         chk_val({1'b0, mode}, {4'b0011, ep[4], es, 1'b0}, "mode output");
      end
      // crystal: settling count, gain stall, then the bit is locked
      reset_dut(cmgc_pkg::CMGC_SRC_MAIN_XTAL);
      stop_release(n, t);
      chk_rng(n, STAB, STAB, "crystal settling");
      reg_wr(8'h00, 8'h01);
      measure(n, t);
      chk_rng(n, T_LO, T_HI, "crystal gain stall");
      reg_wr(8'h00, 8'h00);
      measure(n, t);
      chk_rng(n, 0, 0, "second gain write stall");
      reg_rd(8'h00, d);
      chk_val(d, 8'h01, "gain locked");
      chk_val({7'h00, mode.high_freq_osc_gain_select}, 8'h01, "gain output");
      reg_rd(8'h03, d);
      chk_val(d, 8'h02, "status after stall");
      stop_release(n, t);
      chk_rng(n, STAB, STAB, "crystal settling with gain");
      stall_status(8'h07);
      // external clock input
      reset_dut(cmgc_pkg::CMGC_SRC_MAIN_EXT);
      reg_wr(8'h00, 8'h01);
      measure(n, t);
      chk_rng(t, 160, 160, "external gain stall");
      stop_release(n, t);
      chk_rng(t, 160, 160, "external stop release");
      stall_status(8'h03);
      // internal high-speed clock
      reset_dut(cmgc_pkg::CMGC_SRC_INT_HS);
      stop_release(n, t);
      chk_rng(n, 0, 0, "stop release without gain");
      reg_wr(8'h00, 8'h01);
      measure(n, t);
      chk_rng(n, 0, 0, "internal gain write");
      stop_release(n, t);
      chk_rng(n, T_LO, T_HI, "internal stop release");
      final_report();
   end
endmodule : testbench
